// *** hw/fspa_host.sv ***
`timescale 1ns/1ps
`include "fspa_map.svh"
module fspa_host
  import fspa_pkg::*;
#(
  parameter int PHASE_CYC = `FSPA_PHASE_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire fspa_op_t req_op_i,
  input wire logic [`FSPA_ADDR_W-1:0] req_addr_i,
  input wire logic [7:0] req_data_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic [4:0] rsp_sector_o,
  output logic rsp_prot_o,
  output logic [`FSPA_ADDR_W-1:0] flash_addr_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe_n_o,
  input wire logic [7:0] flash_dq_i,
  output logic flash_a9_hv_o,
  output logic flash_rst_hv_o,
  output logic flash_rst_n_o
);
  typedef enum logic [2:0] {
    FSPA_S_IDLE, FSPA_S_SETUP, FSPA_S_STROBE, FSPA_S_HOLD, FSPA_S_DONE
  } fspa_state_t;

  typedef struct packed {
    fspa_state_t st;
    logic [7:0] cnt;
    logic [2:0] step;
    logic [2:0] nsteps;
    fspa_op_t op;
    logic is_read;
    logic [`FSPA_ADDR_W-1:0] addr;
    logic [7:0] data;
    logic ready;
    logic rvalid;
    logic [7:0] rdata;
    logic [4:0] rsect;
    logic rprot;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic a9_hv;
    logic rst_hv;
    logic [`FSPA_ADDR_W-1:0] bus_addr;
    logic [7:0] bus_dq;
    logic rst_n;
  } fspa_host_t;

  fspa_host_t s_reg, s_next;
  logic [4:0] sector;
  logic [`FSPA_ADDR_W-1:0] cyc_addr;
  logic [7:0] cyc_data;
  logic cyc_read;

  fspa_sector_dec u_dec (
    .upper_i(s_reg.addr[`FSPA_SECT_HI:`FSPA_SECT_LO]),
    .sector_o(sector)
  );

  // per-step bus cycle of each sequence; unlock cycles precede program and command autoselect
  always_comb begin
    cyc_addr = s_reg.addr;
    cyc_data = s_reg.data;
    cyc_read = 1'b0;
    case (s_reg.op)
      FSPA_OP_READ, FSPA_OP_ID_HV: cyc_read = 1'b1;
      FSPA_OP_RESET: cyc_data = `FSPA_CMD_RESET;
      FSPA_OP_ID_CMD, FSPA_OP_PROG: begin
        case (s_reg.step)
          3'h0: begin
            cyc_addr = `FSPA_UNLK1_ADDR;
            cyc_data = `FSPA_UNLK1_DATA;
          end
          3'h1: begin
            cyc_addr = `FSPA_UNLK2_ADDR;
            cyc_data = `FSPA_UNLK2_DATA;
          end
          3'h2: begin
            cyc_addr = `FSPA_UNLK1_ADDR;
            cyc_data = (s_reg.op == FSPA_OP_PROG) ? `FSPA_CMD_PROG : `FSPA_CMD_AUTOSEL;
          end
          3'h3: begin
            cyc_read = (s_reg.op == FSPA_OP_ID_CMD);
          end
          3'h4: cyc_data = `FSPA_CMD_RESET;
          default: cyc_read = 1'b0;
        endcase
      end
      default: cyc_read = 1'b0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    // flash reset pin follows the system reset so the flash also starts in array read
    s_next.rst_n = 1'b1;
    case (s_reg.st)
      FSPA_S_IDLE: begin
        s_next.ready = 1'b1;
        if (req_valid_i && s_reg.ready) begin
          s_next.ready = 1'b0;
          s_next.op = req_op_i;
          s_next.addr = req_addr_i;
          s_next.data = req_data_i;
          s_next.step = 3'h0;
          s_next.cnt = 8'h0;
          case (req_op_i)
            FSPA_OP_TEMP_ON: begin
              s_next.rst_hv = 1'b1;
              s_next.st = FSPA_S_DONE;
            end
            FSPA_OP_TEMP_OFF: begin
              s_next.rst_hv = 1'b0;
              s_next.st = FSPA_S_DONE;
            end
            FSPA_OP_ID_HV: begin
              s_next.a9_hv = 1'b1;
              s_next.addr[6] = 1'b0;
              s_next.nsteps = 3'h1;
              s_next.st = FSPA_S_SETUP;
            end
            FSPA_OP_ID_CMD: begin
              s_next.nsteps = 3'h5;
              s_next.st = FSPA_S_SETUP;
            end
            FSPA_OP_PROG: begin
              s_next.nsteps = 3'h4;
              s_next.st = FSPA_S_SETUP;
            end
            default: begin
              s_next.nsteps = 3'h1;
              s_next.st = FSPA_S_SETUP;
            end
          endcase
        end
      end
      FSPA_S_SETUP: begin
        // address and data settle with ce_n low and oe_n/we_n still high before the cycle opens
        s_next.is_read = cyc_read;
        s_next.bus_addr = cyc_addr;
        s_next.bus_dq = cyc_data;
        s_next.ce_n = 1'b0;
        s_next.dq_oe_n = cyc_read;
        s_next.cnt = s_reg.cnt + 8'h1;
        if (s_reg.cnt == 8'(PHASE_CYC - 1)) begin
          s_next.cnt = 8'h0;
          s_next.oe_n = ~cyc_read;
          s_next.we_n = cyc_read;
          s_next.st = FSPA_S_STROBE;
        end
      end
      FSPA_S_STROBE: begin
        // strobes held a full phase, far beyond the glitch filter
        s_next.cnt = s_reg.cnt + 8'h1;
        if (s_reg.cnt == 8'(PHASE_CYC - 1)) begin
          s_next.cnt = 8'h0;
          if (s_reg.is_read) begin
            s_next.rdata = flash_dq_i;
            s_next.rprot = (s_reg.addr[1:0] == `FSPA_SEL_PROT) && (flash_dq_i == `FSPA_PROT_YES);
          end
          s_next.oe_n = 1'b1;
          s_next.we_n = 1'b1;
          s_next.st = FSPA_S_HOLD;
        end
      end
      FSPA_S_HOLD: begin
        s_next.ce_n = 1'b1;
        s_next.dq_oe_n = 1'b1;
        s_next.cnt = s_reg.cnt + 8'h1;
        if (s_reg.cnt == 8'(PHASE_CYC - 1)) begin
          s_next.cnt = 8'h0;
          s_next.step = s_reg.step + 3'h1;
          s_next.st = (s_reg.step + 3'h1 == s_reg.nsteps) ? FSPA_S_DONE : FSPA_S_SETUP;
        end
      end
      FSPA_S_DONE: begin
        s_next.a9_hv = 1'b0;
        s_next.rvalid = 1'b1;
        s_next.rsect = sector;
        s_next.ready = 1'b1;
        s_next.st = FSPA_S_IDLE;
      end
      default: s_next.st = FSPA_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      // strobes idle high from reset so no write is seen at power-up
      s_reg <= '0;
      s_reg.st <= FSPA_S_IDLE;
      s_reg.op <= FSPA_OP_READ;
      s_reg.ce_n <= 1'b1;
      s_reg.oe_n <= 1'b1;
      s_reg.we_n <= 1'b1;
      s_reg.dq_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign req_ready_o = s_reg.ready;
  assign rsp_valid_o = s_reg.rvalid;
  assign rsp_data_o = s_reg.rdata;
  assign rsp_sector_o = s_reg.rsect;
  assign rsp_prot_o = s_reg.rprot;
  assign flash_addr_o = s_reg.bus_addr;
  assign flash_ce_n_o = s_reg.ce_n;
  assign flash_oe_n_o = s_reg.oe_n;
  assign flash_we_n_o = s_reg.we_n;
  assign flash_dq_o = s_reg.bus_dq;
  assign flash_dq_oe_n_o = s_reg.dq_oe_n;
  assign flash_a9_hv_o = s_reg.a9_hv;
  assign flash_rst_hv_o = s_reg.rst_hv;
  assign flash_rst_n_o = s_reg.rst_n;

  a_write_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !flash_we_n_o |-> (!flash_ce_n_o && flash_oe_n_o))
    else $error("write strobe without chip enable or with output enable");
  a_strobe_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(flash_we_n_o) |-> !flash_we_n_o [*2])
    else $error("write strobe too short");
  a_idle_strobes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(sys_rst_i) |-> (flash_we_n_o && flash_ce_n_o))
    else $error("strobes active right after reset");
  a_id_a6_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (flash_a9_hv_o && !flash_oe_n_o) |-> !flash_addr_o[6])
    else $error("id read with a6 high");
  a_temp_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_reg.st != FSPA_S_IDLE && $past(s_reg.st) != FSPA_S_IDLE) |-> $stable(flash_rst_hv_o))
    else $error("reset detect changed mid operation");
  a_prot_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rsp_valid_o && rsp_prot_o |-> rsp_data_o == `FSPA_PROT_YES)
    else $error("protect flag without 01h");
  a_resp_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rsp_valid_o |-> req_ready_o ##1 !rsp_valid_o)
    else $error("response not a single pulse");
  a_dq_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !flash_oe_n_o |-> flash_dq_oe_n_o)
    else $error("host drives data during a read");
  // no sector-unprotect cycle is ever issued, so protecting all sectors first stays with the user
  a_no_unprot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (flash_rst_hv_o && !flash_we_n_o) |-> !flash_a9_hv_o)
    else $error("sector unprotect cycle issued");
endmodule : fspa_host

// *** hw/fspa_map.svh ***
`ifndef FSPA_MAP_SVH
`define FSPA_MAP_SVH
// flash address layout
`define FSPA_ADDR_W 20
`define FSPA_SECT_HI 19
`define FSPA_SECT_LO 13
// autoselect low-address selectors
`define FSPA_SEL_MFR 2'h0
`define FSPA_SEL_DEV 2'h1
`define FSPA_SEL_PROT 2'h2
`define FSPA_SEL_CONT 2'h3
`define FSPA_PROT_YES 8'h01
`define FSPA_PROT_NO 8'h00
// command cycles
`define FSPA_UNLK1_ADDR 20'h00555
`define FSPA_UNLK1_DATA 8'hAA
`define FSPA_UNLK2_ADDR 20'h002AA
`define FSPA_UNLK2_DATA 8'h55
`define FSPA_CMD_AUTOSEL 8'h90
`define FSPA_CMD_RESET 8'hF0
`define FSPA_CMD_PROG 8'hA0
// strobe timing: cycles per bus phase, well above the glitch filter width
`define FSPA_GLITCH_NS 5
`define FSPA_CLK_NS 10
`define FSPA_PHASE_NS 80
`define FSPA_PHASE_CYC ((`FSPA_PHASE_NS + `FSPA_CLK_NS - 1) / `FSPA_CLK_NS)
`define FSPA_SECTORS 19
`endif

// *** hw/fspa_pkg.sv ***
package fspa_pkg;
  typedef enum logic [2:0] {
    FSPA_OP_READ,
    FSPA_OP_WRITE,
    FSPA_OP_ID_HV,
    FSPA_OP_ID_CMD,
    FSPA_OP_PROG,
    FSPA_OP_TEMP_ON,
    FSPA_OP_TEMP_OFF,
    FSPA_OP_RESET
  } fspa_op_t;
endpackage : fspa_pkg

// *** hw/fspa_sector_dec.sv ***
`timescale 1ns/1ps
`include "fspa_map.svh"
// bottom-boot sector map: 16K, 8K, 8K, 32K, then fifteen 64K sectors
module fspa_sector_dec (
  input wire logic [6:0] upper_i,
  output logic [4:0] sector_o
);
  always_comb begin
    if (upper_i[6:3] != 4'h0) begin
      sector_o = 5'(upper_i[6:3]) + 5'h3;
    end else if (upper_i[2]) begin
      sector_o = 5'h3;
    end else if (upper_i[1]) begin
      sector_o = upper_i[0] ? 5'h2 : 5'h1;
    end else begin
      sector_o = 5'h0;
    end
  end
endmodule : fspa_sector_dec

// *** test/fspa_flash_model.sv ***
`timescale 1ns/1ps
module fspa_flash_model #(
  parameter logic [18:0] PROT_MASK = 19'h00000,
  parameter logic [7:0] MFR_CODE = 8'hC4, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5D, // arbitrary value
  parameter logic [7:0] CONT_CODE = 8'hE2 // arbitrary value
) (
  input wire logic [19:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] dq_i,
  input wire logic a9_hv_i,
  input wire logic rst_hv_i,
  output logic [7:0] dq_o
);
  logic [7:0] mem [logic [19:0]];
  logic [1:0] step = 2'h0;
  logic autosel = 1'b0;
  logic prog_on = 1'b0;
  logic armed = 1'b0;
  logic [7:0] rd;
  realtime t_fall = 0;
  function automatic int sect(input logic [19:0] a);
    if (a[19:16] != 4'h0) return 3 + a[19:16];
    if (a[15]) return 3;
    return a[14] ? (a[13] ? 2 : 1) : 0;
  endfunction : sect
  // a strobe already low at power-up never counts as a write
  always @(negedge we_n_i) begin
    t_fall = $realtime;
    if ($realtime > 0) armed = 1'b1;
  end
  always @(posedge we_n_i) begin
    if (armed && !ce_n_i && oe_n_i && ($realtime - t_fall >= 5.0)) begin
      if (dq_i == 8'hF0) begin
        autosel = 1'b0;
        prog_on = 1'b0;
        step = 2'h0;
      end else if (prog_on) begin
        if (!PROT_MASK[sect(addr_i)] || rst_hv_i) begin
          mem[addr_i] = (mem.exists(addr_i) ? mem[addr_i] : 8'hFF) & dq_i;
        end
        prog_on = 1'b0;
      end else if (step == 2'h0 && addr_i[11:0] == 12'h555 && dq_i == 8'hAA) step = 2'h1;
      else if (step == 2'h1 && addr_i[11:0] == 12'h2AA && dq_i == 8'h55) step = 2'h2;
      else if (step == 2'h2 && addr_i[11:0] == 12'h555 && dq_i == 8'h90) begin
        autosel = 1'b1;
        step = 2'h0;
      end else if (step == 2'h2 && addr_i[11:0] == 12'h555 && dq_i == 8'hA0) begin
        prog_on = 1'b1;
        step = 2'h0;
      end else step = 2'h0;
    end
  end
  always_comb begin
    if ((a9_hv_i && !addr_i[6]) || autosel) begin
      case (addr_i[1:0])
        2'h0: rd = MFR_CODE;
        2'h1: rd = DEV_CODE;
        2'h2: rd = PROT_MASK[sect(addr_i)] ? 8'h01 : 8'h00;
        default: rd = CONT_CODE;
      endcase
    end else rd = mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
    // released bus shows the inverse so a stale byte cannot pass
    dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
  end
endmodule : fspa_flash_model

// *** test/fspa_host_test.sv ***
`timescale 1ns/1ps
module fspa_host_test
  import fspa_pkg::*;
();
  localparam logic [7:0] MFR = 8'hC4;
  localparam logic [7:0] DEV = 8'h5D;
  localparam logic [7:0] CONT = 8'hE2;
  localparam logic [19:0] MAP_A [10] = '{20'h00000, 20'h03FFF, 20'h04000, 20'h05FFF, 20'h06000,
    20'h07FFF, 20'h08000, 20'h0FFFF, 20'h10000, 20'hFFFFF};
  localparam logic [4:0] MAP_S [10] = '{5'h00, 5'h00, 5'h01, 5'h01, 5'h02, 5'h02, 5'h03, 5'h03, 5'h04, 5'h12};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  fspa_op_t req_op_i = FSPA_OP_READ;
  logic [19:0] req_addr_i = 20'h00000;
  logic [7:0] req_data_i = 8'h00;
  logic req_ready_o, rsp_valid_o, rsp_prot_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
  logic flash_dq_oe_n_o, flash_a9_hv_o, flash_rst_hv_o, flash_rst_n_o;
  logic [7:0] rsp_data_o, flash_dq_o, flash_dq_i;
  logic [4:0] rsp_sector_o;
  logic [19:0] flash_addr_o;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 clk_i = ~clk_i;
  fspa_host #(.PHASE_CYC(2)) u_dut (.*);
  fspa_flash_model #(.PROT_MASK(19'h00008), .MFR_CODE(MFR), .DEV_CODE(DEV), .CONT_CODE(CONT)) u_flash (
    .addr_i(flash_addr_o), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
    .dq_i(flash_dq_o), .a9_hv_i(flash_a9_hv_o), .rst_hv_i(flash_rst_hv_o), .dq_o(flash_dq_i));
  task automatic close_out;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // the run needs well under a thousand cycles; this ceiling only catches a hang
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : cmp8
  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
      errors++;
    end
  endtask : cmp1
  // entered at a falling edge; holds the request until the edge that takes it
  task automatic op(input fspa_op_t o, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    req_op_i = o;
    req_addr_i = a;
    req_data_i = d;
    req_valid_i = 1'b1;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    cmp1("response", 1'b1, rsp_valid_o);
  endtask : op
  task automatic t_map;
    for (int i = 0; i < 10; i++) begin
      op(FSPA_OP_READ, MAP_A[i], 8'h00);
      cmp8("sector", {3'h0, MAP_S[i]}, {3'h0, rsp_sector_o});
      cmp8("blank", 8'hFF, rsp_data_o);
    end
  endtask : t_map
  task automatic t_id(input fspa_op_t o);
    op(o, 20'h00040, 8'h00);
    cmp8("mfr", MFR, rsp_data_o);
    op(o, 20'h00001, 8'h00);
    cmp8("dev", DEV, rsp_data_o);
    op(o, 20'h00003, 8'h00);
    cmp8("cont", CONT, rsp_data_o);
    op(o, 20'h08002, 8'h00);
    cmp8("prot", 8'h01, rsp_data_o);
    cmp1("prot flag", 1'b1, rsp_prot_o);
    op(o, 20'h10002, 8'h00);
    cmp8("unprot", 8'h00, rsp_data_o);
    cmp1("unprot flag", 1'b0, rsp_prot_o);
    op(FSPA_OP_READ, 20'h00001, 8'h00);
    cmp8("array mode", 8'hFF, rsp_data_o);
    cmp1("a9 hv", 1'b0, flash_a9_hv_o);
  endtask : t_id
  task automatic t_reset;
    op(FSPA_OP_WRITE, 20'h00555, 8'hAA);
    op(FSPA_OP_WRITE, 20'h002AA, 8'h55);
    op(FSPA_OP_WRITE, 20'h00555, 8'h90);
    op(FSPA_OP_READ, 20'h00001, 8'h00);
    cmp8("manual id", DEV, rsp_data_o);
    op(FSPA_OP_RESET, 20'h00000, 8'h00);
    op(FSPA_OP_READ, 20'h00001, 8'h00);
    cmp8("after reset", 8'hFF, rsp_data_o);
    cmp1("flash reset pin", 1'b1, flash_rst_n_o);
  endtask : t_reset
  task automatic pr(input fspa_op_t o, input logic [19:0] a, input logic [7:0] exp);
    op(o, a, 8'h5A);
    op(FSPA_OP_READ, a, 8'h00);
    cmp8("array", exp, rsp_data_o);
  endtask : pr
  task automatic t_prog;
    pr(FSPA_OP_PROG, 20'h00010, 8'h5A);
    pr(FSPA_OP_WRITE, 20'h00020, 8'hFF);
    pr(FSPA_OP_PROG, 20'h08010, 8'hFF);
    op(FSPA_OP_TEMP_ON, 20'h00000, 8'h00);
    cmp1("rst hv", 1'b1, flash_rst_hv_o);
    pr(FSPA_OP_PROG, 20'h08010, 8'h5A);
    op(FSPA_OP_TEMP_OFF, 20'h00000, 8'h00);
    cmp1("rst hv", 1'b0, flash_rst_hv_o);
    pr(FSPA_OP_PROG, 20'h08020, 8'hFF);
  endtask : t_prog
  initial begin
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_map();
    t_id(FSPA_OP_ID_HV);
    t_id(FSPA_OP_ID_CMD);
    t_prog();
    t_reset();
    close_out();
  end
endmodule : fspa_host_test
